// >>> core/nrf_regfile.sv
// nibble register file: control registers plus banked data memory alias
`timescale 1ns/1ns
`default_nettype none

module nrf_regfile #(
    parameter int         NUM_BANKS = 16,
    parameter logic [3:0] UNDEF_VAL = 4'h0
) (
    // clock and reset
    input  wire logic          clk_sys,
    input  wire logic          rst_n,
    // transfer instruction from the core
    input  wire logic          rf_req,
    input  wire logic          rf_we,
    input  wire logic [6:0]    regfile_location_address,
    input  wire logic [3:0]    window_in,
    input  wire logic [3:0]    bank_sel,
    // transfer answer
    output logic               rf_rvalid,
    output logic [3:0]         window_out,
    output logic               rf_undef,
    // ordinary data memory access
    input  wire logic          dm_req,
    input  wire logic          dm_we,
    input  wire logic [6:0]    dm_addr,
    input  wire logic [3:0]    dm_wdata,
    output logic               dm_rvalid,
    output logic [3:0]         dm_rdata,
    // peripheral side of the control registers
    output logic [255:0]       ctrl_q,
    output logic [63:0]        ctrl_wr_stb,
    input  wire logic [255:0]  hw_ro_val,
    input  wire logic [255:0]  hw_flag_set,
    // port direction select registers
    output logic               pio_we,
    output logic [3:0]         pio_addr,
    output logic [3:0]         pio_wdata,
    input  wire logic [3:0]    pio_rdata
);

    logic [3:0]  ctrl_ff [nrf_pkg::NUM_CTRL];
    logic [63:0] wr_hit;
    logic [63:0] fz_bad;
    logic [5:0]  cidx;
    logic        rf_ctrl;
    logic        rf_alias;
    logic        rf_pio;
    logic        dm_go;
    logic        dm_pio;
    logic        m_we;
    logic [10:0] m_addr;
    logic [3:0]  m_wdata;
    logic [3:0]  m_rdata;
    logic [3:0]  cur_mask;
    nrf_pkg::nrf_attr_t cur_attr;
    logic        rf_rvalid_ff;
    logic [3:0]  window_out_ff;
    logic        rf_undef_ff;
    logic        dm_rvalid_ff;
    logic [3:0]  dm_rdata_ff;
    logic [63:0] ctrl_wr_stb_ff;

    // address decode
    assign cidx     = regfile_location_address[5:0];
    assign rf_ctrl  = rf_req && (regfile_location_address <= nrf_pkg::CTRL_LAST);
    assign rf_alias = rf_req && (regfile_location_address >= nrf_pkg::ALIAS_FIRST);
    assign rf_pio   = rf_alias && (bank_sel == nrf_pkg::PIO_BANK)
                   && (regfile_location_address >= nrf_pkg::PIO_FIRST)
                   && (regfile_location_address <= nrf_pkg::PIO_LAST);
    // an alias transfer owns the shared memory port; a clashing access is dropped
    assign dm_go    = dm_req && !rf_alias;
    assign dm_pio   = dm_go && (bank_sel == nrf_pkg::PIO_BANK)
                   && (dm_addr >= nrf_pkg::PIO_FIRST) && (dm_addr <= nrf_pkg::PIO_LAST);
    assign cur_attr = nrf_pkg::attr_of(cidx);
    assign cur_mask = nrf_pkg::mask_of(cidx);

    // shared memory port, one storage for both paths
    assign m_we    = (rf_alias && rf_we && !rf_pio) || (dm_go && dm_we && !dm_pio);
    assign m_addr  = rf_alias ? {bank_sel, regfile_location_address} : {bank_sel, dm_addr};
    assign m_wdata = rf_alias ? window_in : dm_wdata;

    nrf_bank_mem #(
        .NUM_BANKS (NUM_BANKS)
    ) u_mem (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .we      (m_we),
        .addr    (m_addr),
        .wdata   (m_wdata),
        .rdata   (m_rdata)
    );

    // direction select registers live outside this block
    assign pio_we    = (rf_pio && rf_we) || (dm_pio && dm_we);
    assign pio_addr  = rf_pio ? regfile_location_address[3:0] : dm_addr[3:0];
    assign pio_wdata = rf_pio ? window_in : dm_wdata;

    // one storage process per control nibble
    for (genvar i = 0; i < nrf_pkg::NUM_CTRL; i++)
    begin : g_ctrl
        localparam nrf_pkg::nrf_attr_t ATTR = nrf_pkg::attr_of(6'(i));
        localparam logic [3:0]         MASK = nrf_pkg::mask_of(6'(i));
        logic hit;

        assign hit = rf_ctrl && (cidx == 6'(i));

        always_ff @(posedge clk_sys or negedge rst_n)
        begin
            if (!rst_n)
                ctrl_ff[i] <= nrf_pkg::CTRL_RST;
            else if (ATTR == nrf_pkg::ATTR_RC)
                // a new flag set beats the clear-on-read
                ctrl_ff[i] <= ((hit && !rf_we) ? 4'h0 : ctrl_ff[i])
                            | (hw_flag_set[i*4 +: 4] & MASK);
            else if (ATTR == nrf_pkg::ATTR_RO)
                ctrl_ff[i] <= hw_ro_val[i*4 +: 4] & MASK;
            else if (hit && rf_we && ATTR != nrf_pkg::ATTR_UNUSED)
                ctrl_ff[i] <= window_in & MASK;
        end

        assign wr_hit[i] = hit && rf_we
                        && (ATTR == nrf_pkg::ATTR_RW || ATTR == nrf_pkg::ATTR_WO);
        assign fz_bad[i] = |(ctrl_ff[i] & ~MASK);
        assign ctrl_q[i*4 +: 4] = ctrl_ff[i];
    end

    // transfer read answer
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rf_rvalid_ff  <= 1'b0;
            window_out_ff <= 4'h0;
            rf_undef_ff   <= 1'b0;
        end
        else
        begin
            rf_rvalid_ff <= rf_req && !rf_we;
            if (rf_req && !rf_we)
            begin
                if (rf_ctrl && (cur_attr == nrf_pkg::ATTR_UNUSED
                             || cur_attr == nrf_pkg::ATTR_WO))
                begin
                    window_out_ff <= UNDEF_VAL;
                    rf_undef_ff   <= 1'b1;
                end
                else if (rf_ctrl)
                begin
                    window_out_ff <= ctrl_ff[cidx] & cur_mask;
                    rf_undef_ff   <= 1'b0;
                end
                else
                begin
                    window_out_ff <= rf_pio ? pio_rdata : m_rdata;
                    rf_undef_ff   <= 1'b0;
                end
            end
        end
    end

    // ordinary data memory answer
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dm_rvalid_ff <= 1'b0;
            dm_rdata_ff  <= 4'h0;
        end
        else
        begin
            dm_rvalid_ff <= dm_go && !dm_we;
            if (dm_go && !dm_we)
                dm_rdata_ff <= dm_pio ? pio_rdata : m_rdata;
        end
    end

    // write strobes to peripherals, registered on the same edge as the store
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            ctrl_wr_stb_ff <= 64'h0;
        else
            ctrl_wr_stb_ff <= wr_hit;
    end

    assign rf_rvalid   = rf_rvalid_ff;
    assign window_out  = window_out_ff;
    assign rf_undef    = rf_undef_ff;
    assign dm_rvalid   = dm_rvalid_ff;
    assign dm_rdata    = dm_rdata_ff;
    assign ctrl_wr_stb = ctrl_wr_stb_ff;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    property p_rd_lat;
        rf_req && !rf_we |=> rf_rvalid;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer missing");

    property p_rw_store;
        rf_ctrl && rf_we && cur_attr == nrf_pkg::ATTR_RW
        |=> ctrl_ff[$past(cidx)] == ($past(window_in) & $past(cur_mask));
    endproperty
    a_rw_store: assert property (p_rw_store) else $error("write not stored");

    property p_rw_readback;
        rf_ctrl && rf_we && cur_attr == nrf_pkg::ATTR_RW ##1
        rf_ctrl && !rf_we && cidx == $past(cidx)
        |=> window_out == ($past(window_in, 2) & $past(cur_mask, 2)) && !rf_undef;
    endproperty
    a_rw_readback: assert property (p_rw_readback) else $error("bad readback");

    property p_rc_nowrite;
        rf_ctrl && rf_we && cur_attr == nrf_pkg::ATTR_RC
        && hw_flag_set[{cidx, 2'b00} +: 4] == 4'h0
        |=> ctrl_ff[$past(cidx)] == $past(ctrl_ff[cidx]);
    endproperty
    a_rc_nowrite: assert property (p_rc_nowrite) else $error("flag written");

    property p_rc_clear;
        rf_ctrl && !rf_we && cur_attr == nrf_pkg::ATTR_RC
        && hw_flag_set[{cidx, 2'b00} +: 4] == 4'h0
        |=> ctrl_ff[$past(cidx)] == 4'h0 && window_out == $past(ctrl_ff[cidx]);
    endproperty
    a_rc_clear: assert property (p_rc_clear) else $error("flag not cleared");

    property p_wo_undef;
        rf_ctrl && !rf_we && cur_attr == nrf_pkg::ATTR_WO
        |=> rf_undef && window_out == UNDEF_VAL;
    endproperty
    a_wo_undef: assert property (p_wo_undef) else $error("write-only read");

    property p_unused;
        rf_ctrl && cur_attr == nrf_pkg::ATTR_UNUSED
        |=> ctrl_wr_stb == 64'h0 && (rf_undef || !rf_rvalid);
    endproperty
    a_unused: assert property (p_unused) else $error("unused nibble acted");

    property p_fixed_zero;
        fz_bad == 64'h0;
    endproperty
    a_fixed_zero: assert property (p_fixed_zero) else $error("fixed-zero bit set");

    property p_pio;
        rf_pio && rf_we |-> pio_we && !m_we && pio_wdata == window_in;
    endproperty
    a_pio: assert property (p_pio) else $error("port select not diverted");

    property p_alias;
        rf_alias && !rf_pio && rf_we ##1
        dm_go && !dm_we && !rf_alias && dm_addr == $past(regfile_location_address)
        && bank_sel == $past(bank_sel)
        |=> dm_rdata == $past(window_in, 2);
    endproperty
    a_alias: assert property (p_alias) else $error("alias mismatch");

    property p_ro_write;
        rf_ctrl && rf_we && cur_attr == nrf_pkg::ATTR_RO
        |=> ctrl_ff[$past(cidx)] == ($past(hw_ro_val[{cidx, 2'b00} +: 4]) & $past(cur_mask));
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only nibble written");

    property p_wr_stb;
        rf_ctrl && rf_we && (cur_attr == nrf_pkg::ATTR_RW || cur_attr == nrf_pkg::ATTR_WO)
        |=> ctrl_wr_stb == (64'h1 << $past(cidx));
    endproperty
    a_wr_stb: assert property (p_wr_stb) else $error("write strobe wrong");

    // a clashing plain access gets no answer, so the core must retry it
    property p_dm_drop;
        dm_req && rf_alias |=> !dm_rvalid;
    endproperty
    a_dm_drop: assert property (p_dm_drop) else $error("clashing access answered");

    property p_dm_lat;
        dm_go && !dm_we |=> dm_rvalid;
    endproperty
    a_dm_lat: assert property (p_dm_lat) else $error("memory answer missing");

    c_rc_read:  cover property (rf_ctrl && !rf_we && cur_attr == nrf_pkg::ATTR_RC);
    c_alias_wr: cover property (rf_alias && rf_we && !rf_pio);
    c_pio_wr:   cover property (pio_we);
    c_wo_write: cover property (rf_ctrl && rf_we && cur_attr == nrf_pkg::ATTR_WO);
    c_clash:    cover property (dm_req && rf_alias);

endmodule

`default_nettype wire

// >>> core/nrf_pkg.sv
// constants, register map and access attributes of the nibble register file
package nrf_pkg;

    localparam int NIB_W    = 4;
    localparam int ADDR_W   = 7;
    localparam int BANK_W   = 4;
    localparam int NUM_CTRL = 64;
    localparam int NUM_COLS = 16;
    localparam int NUM_LOCS = 128;

    // region limits of the nibble address space
    localparam logic [6:0] CTRL_LAST   = 7'h3f;
    localparam logic [6:0] ALIAS_FIRST = 7'h40;
    localparam logic [6:0] PIO_FIRST   = 7'h60;
    localparam logic [6:0] PIO_LAST    = 7'h6f;
    localparam logic [3:0] PIO_BANK    = 4'hf;
    localparam logic [3:0] CTRL_RST    = 4'h0;

    // control register address from row and column
    function automatic logic [5:0] ctrl_addr(input int row, input int col);
        return 6'(row * NUM_COLS + col);
    endfunction

    localparam logic [5:0] STACK_POINTER_ADDR            = ctrl_addr(0, 1);
    localparam logic [5:0] WATCHDOG_CLOCK_SELECT_ADDR    = ctrl_addr(0, 2);
    localparam logic [5:0] WATCHDOG_RESTART_ADDR         = ctrl_addr(0, 3);
    localparam logic [5:0] BUFFER_STACK_POINTER_ADDR     = ctrl_addr(0, 4);
    localparam logic [5:0] STACK_FAULT_RESET_SELECT_ADDR = ctrl_addr(0, 5);
    localparam logic [5:0] CHIP_ENABLE_RESET_COUNTER_ADDR = ctrl_addr(0, 6);
    localparam logic [5:0] TABLE_MOVE_BIT_SELECT_ADDR    = ctrl_addr(0, 7);
    localparam logic [5:0] SYNTH_MODE_SELECT_ADDR        = ctrl_addr(1, 0);
    localparam logic [5:0] SYNTH_REFERENCE_SELECT_ADDR   = ctrl_addr(1, 1);
    localparam logic [5:0] SYNTH_UNLOCK_FLAG_ADDR        = ctrl_addr(1, 2);
    localparam logic [5:0] TONE_PIN_FUNCTION_SELECT_ADDR = ctrl_addr(1, 3);
    localparam logic [5:0] TONE_CLOCK_SELECT_ADDR        = ctrl_addr(1, 4);
    localparam logic [5:0] WATCHDOG_STACK_RESET_CAUSE_ADDR = ctrl_addr(1, 6);
    localparam logic [5:0] INTERVAL_TIMER_CARRY_ADDR     = ctrl_addr(1, 7);

    // eleven unused nibbles
    localparam logic [63:0] UNUSED_MAP = 64'h0300_0100_0720_0701;
    localparam logic [63:0] RO_MAP     = 64'h1 << BUFFER_STACK_POINTER_ADDR;
    localparam logic [63:0] WO_MAP     = 64'h1 << WATCHDOG_RESTART_ADDR;
    localparam logic [63:0] RC_MAP     = (64'h1 << SYNTH_UNLOCK_FLAG_ADDR)
                                       | (64'h1 << WATCHDOG_STACK_RESET_CAUSE_ADDR)
                                       | (64'h1 << INTERVAL_TIMER_CARRY_ADDR);

    // fixed-zero masks: set bits are implemented
    localparam logic [3:0] FLAG_MASK = 4'h1;
    localparam logic [3:0] MOVT_MASK = 4'h3;
    localparam logic [3:0] FULL_MASK = 4'hf;

    typedef enum logic [4:0] {
        ATTR_UNUSED = 5'b00001,
        ATTR_RW     = 5'b00010,
        ATTR_RO     = 5'b00100,
        ATTR_WO     = 5'b01000,
        ATTR_RC     = 5'b10000
    } nrf_attr_t;

    function automatic nrf_attr_t attr_of(input logic [5:0] a);
        if (UNUSED_MAP[a])
            return ATTR_UNUSED;
        else if (RO_MAP[a])
            return ATTR_RO;
        else if (WO_MAP[a])
            return ATTR_WO;
        else if (RC_MAP[a])
            return ATTR_RC;
        return ATTR_RW;
    endfunction

    function automatic logic [3:0] mask_of(input logic [5:0] a);
        if (UNUSED_MAP[a])
            return 4'h0;
        else if (RC_MAP[a])
            return FLAG_MASK;
        else if (a == TABLE_MOVE_BIT_SELECT_ADDR)
            return MOVT_MASK;
        return FULL_MASK;
    endfunction

endpackage

// >>> core/nrf_bank_mem.sv
// banked nibble data memory shared by both access paths
`timescale 1ns/1ns
`default_nettype none

module nrf_bank_mem #(
    parameter int NUM_BANKS = 16
) (
    // clock and reset
    input  wire logic                                     clk_sys,
    input  wire logic                                     rst_n,
    // single shared port
    input  wire logic                                     we,
    input  wire logic [nrf_pkg::BANK_W+nrf_pkg::ADDR_W-1:0] addr,
    input  wire logic [nrf_pkg::NIB_W-1:0]                wdata,
    output logic      [nrf_pkg::NIB_W-1:0]                rdata
);

    localparam int DEPTH = NUM_BANKS * nrf_pkg::NUM_LOCS;

    logic [nrf_pkg::NIB_W-1:0] mem [DEPTH];
    logic                      exists;

    // banks above the fitted count read zero and drop writes
    assign exists = int'(addr[nrf_pkg::BANK_W+nrf_pkg::ADDR_W-1:nrf_pkg::ADDR_W]) < NUM_BANKS;
    assign rdata  = exists ? mem[addr] : 4'h0;

    always_ff @(posedge clk_sys)
    begin
        if (we && exists)
            mem[addr] <= wdata;
    end

    property p_mem_wr;
        @(posedge clk_sys) disable iff (!rst_n)
        we && exists ##1 addr == $past(addr) |-> rdata == $past(wdata);
    endproperty
    a_mem_wr: assert property (p_mem_wr) else $error("stored nibble not read back");

endmodule

`default_nettype wire

// >>> verification/nrf_core_model.sv
// processor core model issuing transfer instructions and data memory accesses
`timescale 1ns/1ns
`default_nettype none

module nrf_core_model (
    // clock
    input  wire logic       clk_sys,
    // transfer instruction
    output logic            rf_req,
    output logic            rf_we,
    output logic [6:0]      regfile_location_address,
    output logic [3:0]      window_in,
    output logic [3:0]      bank_sel,
    input  wire logic       rf_rvalid,
    input  wire logic [3:0] window_out,
    input  wire logic       rf_undef,
    // ordinary data memory access
    output logic            dm_req,
    output logic            dm_we,
    output logic [6:0]      dm_addr,
    output logic [3:0]      dm_wdata,
    input  wire logic       dm_rvalid,
    input  wire logic [3:0] dm_rdata
);
    int stall = 0;

    initial
    begin
        rf_req = 1'b0;
        rf_we = 1'b0;
        regfile_location_address = 7'h00;
        window_in = 4'h0;
        bank_sel = 4'h0;
        dm_req = 1'b0;
        dm_we = 1'b0;
        dm_addr = 7'h00;
        dm_wdata = 4'h0;
    end

    // one instruction, held for exactly one taking edge
    task automatic issue(input logic tf, input logic wr, input logic [6:0] a,
                         input logic [3:0] d, input logic [3:0] bk);
        repeat (stall + 1) @(negedge clk_sys);
        bank_sel <= bk;
        rf_req <= tf;
        rf_we <= wr;
        regfile_location_address <= a;
        window_in <= d;
        dm_req <= !tf;
        dm_we <= wr;
        dm_addr <= a;
        dm_wdata <= d;
        @(negedge clk_sys);
        // released lines show the inverse so stale data never looks live
        rf_req <= 1'b0;
        dm_req <= 1'b0;
        regfile_location_address <= ~a;
        window_in <= ~d;
        dm_addr <= ~a;
        dm_wdata <= ~d;
    endtask

    // back-to-back pair: transfer write, then a read of the same nibble;
    // with dm set a clashing store rides along and the read goes the plain way
    task automatic burst(input logic dm, input logic [6:0] a, input logic [3:0] d,
                         input logic [3:0] bk);
        @(negedge clk_sys);
        bank_sel <= bk;
        rf_req <= 1'b1;
        rf_we <= 1'b1;
        regfile_location_address <= a;
        window_in <= d;
        dm_req <= dm;
        dm_we <= 1'b1;
        dm_addr <= a;
        dm_wdata <= ~d;
        @(negedge clk_sys);
        rf_req <= !dm;
        rf_we <= 1'b0;
        window_in <= ~d;
        dm_we <= 1'b0;
        @(negedge clk_sys);
        rf_req <= 1'b0;
        dm_req <= 1'b0;
        regfile_location_address <= ~a;
        dm_addr <= ~a;
    endtask

    // bounded wait for the read answer pulse
    task automatic answer(input logic tf, output logic [3:0] d, output logic u,
                          output logic ok);
        int n;
        n = 0;
        while (!(tf ? rf_rvalid : dm_rvalid) && n < 3)
        begin
            @(negedge clk_sys);
            n++;
        end
        ok = tf ? rf_rvalid : dm_rvalid;
        d = tf ? window_out : dm_rdata;
        u = tf ? rf_undef : 1'b0;
    endtask
endmodule

`default_nettype wire

// >>> verification/nibble_register_file_test.sv
// self-checking bench of the nibble register file
`timescale 1ns/1ns
`default_nettype none

`define CHK(name, exp, got) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) \
        begin \
            err_count++; \
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got); \
        end \
    end

module nibble_register_file_test;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic rf_req, rf_we, rf_rvalid, rf_undef, dm_req, dm_we, dm_rvalid, pio_we;
    logic [6:0] regfile_location_address, dm_addr;
    logic [3:0] window_in, bank_sel, window_out, dm_wdata, dm_rdata;
    logic [3:0] pio_addr, pio_wdata, pio_seen_addr, pio_seen_data;
    logic [3:0] pio_rdata = 4'hb;
    logic [255:0] ctrl_q;
    logic [63:0] ctrl_wr_stb;
    logic [255:0] hw_ro_val = {64{4'hc}};
    logic [255:0] hw_flag_set = '0;
    int err_count = 0;
    int checks_done = 0;
    int pio_hits = 0;

    always #4 clk_sys = ~clk_sys;

    nrf_regfile dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .rf_req(rf_req), .rf_we(rf_we),
        .regfile_location_address(regfile_location_address), .window_in(window_in),
        .bank_sel(bank_sel), .rf_rvalid(rf_rvalid), .window_out(window_out),
        .rf_undef(rf_undef), .dm_req(dm_req), .dm_we(dm_we), .dm_addr(dm_addr),
        .dm_wdata(dm_wdata), .dm_rvalid(dm_rvalid), .dm_rdata(dm_rdata), .ctrl_q(ctrl_q),
        .ctrl_wr_stb(ctrl_wr_stb), .hw_ro_val(hw_ro_val), .hw_flag_set(hw_flag_set),
        .pio_we(pio_we), .pio_addr(pio_addr), .pio_wdata(pio_wdata), .pio_rdata(pio_rdata));

    nrf_core_model core_u (.clk_sys(clk_sys), .rf_req(rf_req), .rf_we(rf_we),
        .regfile_location_address(regfile_location_address), .window_in(window_in),
        .bank_sel(bank_sel), .rf_rvalid(rf_rvalid), .window_out(window_out),
        .rf_undef(rf_undef), .dm_req(dm_req), .dm_we(dm_we), .dm_addr(dm_addr),
        .dm_wdata(dm_wdata), .dm_rvalid(dm_rvalid), .dm_rdata(dm_rdata));

    // port direction strobes seen on the external side
    always @(posedge clk_sys)
    begin
        if (pio_we === 1'b1)
        begin
            pio_seen_addr <= pio_addr;
            pio_seen_data <= pio_wdata;
            pio_hits <= pio_hits + 1;
        end
    end

    task automatic results();
        if (err_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // 0 unused, 1 write-only, 2 read-only, 3 read-and-reset, 4 read/write
    function automatic int kind(input int a);
        case (a)
            'h00, 'h08, 'h09, 'h0a, 'h15, 'h18, 'h19, 'h1a, 'h28, 'h38, 'h39: return 0;
            'h03: return 1;
            'h04: return 2;
            'h12, 'h16, 'h17: return 3;
            default: return 4;
        endcase
    endfunction

    task automatic regfile_write_instruction(input logic [6:0] a, input logic [3:0] v, input logic [3:0] bk);
        core_u.issue(1'b1, 1'b1, a, v, bk);
    endtask

    task automatic regfile_read_instruction(input logic [6:0] a, input logic [3:0] bk, input logic [3:0] e,
                        input logic ue);
        logic [3:0] d;
        logic u, ok;
        core_u.issue(1'b1, 1'b0, a, 4'h0, bk);
        core_u.answer(1'b1, d, u, ok);
        `CHK("read answer", 1'b1, ok);
        `CHK("undefined flag", ue, u);
        if (!ue)
            `CHK("window nibble", e, d);
    endtask

    task automatic dm_access(input logic wr, input logic [6:0] a, input logic [3:0] v,
                             input logic [3:0] bk);
        logic [3:0] d;
        logic u, ok;
        core_u.issue(1'b0, wr, a, v, bk);
        if (!wr)
        begin
            core_u.answer(1'b0, d, u, ok);
            `CHK("memory answer", 1'b1, ok);
            `CHK("memory nibble", v, d);
        end
    endtask

    // every control nibble: write a pattern, read it back by attribute
    task automatic t_map();
        logic [3:0] v, e;
        int k;
        for (int a = 0; a < 64; a++)
        begin
            v = 4'(a) ^ 4'h9;
            k = kind(a);
            e = (k == 2) ? 4'hc : (k == 3) ? 4'h0 : v & ((a == 'h07) ? 4'h3 : 4'hf);
            regfile_write_instruction(7'(a), v, 4'h0);
            `CHK("strobe", (k == 1 || k == 4) ? 64'h1 << a : 64'h0, ctrl_wr_stb);
            regfile_read_instruction(7'(a), 4'h0, e, k < 2);
            if (k == 4)
                `CHK("control output", e, ctrl_q[4*a +: 4]);
            if (k == 0)
                `CHK("unused untouched", 4'h0, ctrl_q[4*a +: 4]);
        end
    endtask

    // flag set by hardware, read once with flag, then cleared
    task automatic t_flags();
        int fl[3] = '{'h12, 'h16, 'h17};
        foreach (fl[i])
        begin
            @(negedge clk_sys);
            hw_flag_set[4*fl[i]] = 1'b1;
            @(negedge clk_sys);
            hw_flag_set[4*fl[i]] = 1'b0;
            regfile_read_instruction(7'(fl[i]), 4'h0, 4'h1, 1'b0);
            regfile_read_instruction(7'(fl[i]), 4'h0, 4'h0, 1'b0);
            // a flag raised in the very cycle of the read survives the clear
            fork
                regfile_read_instruction(7'(fl[i]), 4'h0, 4'h0, 1'b0);
                begin
                    @(negedge clk_sys);
                    hw_flag_set[4*fl[i]] = 1'b1;
                    @(negedge clk_sys);
                    hw_flag_set[4*fl[i]] = 1'b0;
                end
            join
            regfile_read_instruction(7'(fl[i]), 4'h0, 4'h1, 1'b0);
        end
    endtask

    // upper half reaches the current bank through both paths, slow core
    task automatic t_alias();
        core_u.stall = 2;
        regfile_write_instruction(7'h45, 4'ha, 4'h3);
        dm_access(1'b1, 7'h45, 4'h2, 4'h4);
        dm_access(1'b0, 7'h45, 4'ha, 4'h3);
        regfile_read_instruction(7'h45, 4'h4, 4'h2, 1'b0);
        dm_access(1'b1, 7'h7f, 4'h5, 4'h3);
        regfile_read_instruction(7'h7f, 4'h3, 4'h5, 1'b0);
        dm_access(1'b1, 7'h40, 4'h6, 4'h3);
        regfile_read_instruction(7'h40, 4'h3, 4'h6, 1'b0);
        core_u.stall = 0;
    endtask

    // bank 15 direction select window versus plain memory
    task automatic t_pio();
        regfile_write_instruction(7'h63, 4'h7, 4'hf);
        `CHK("direction strobes", 1, pio_hits);
        `CHK("direction address", 4'h3, pio_seen_addr);
        `CHK("direction data", 4'h7, pio_seen_data);
        regfile_read_instruction(7'h6a, 4'hf, 4'hb, 1'b0);
        regfile_write_instruction(7'h63, 4'h9, 4'he);
        regfile_write_instruction(7'h70, 4'h4, 4'hf);
        `CHK("no stray strobes", 1, pio_hits);
        dm_access(1'b1, 7'h65, 4'h3, 4'hf);
        `CHK("plain-path strobes", 2, pio_hits);
        `CHK("plain-path address", 4'h5, pio_seen_addr);
        `CHK("plain-path data", 4'h3, pio_seen_data);
        dm_access(1'b0, 7'h6c, 4'hb, 4'hf);
        regfile_read_instruction(7'h63, 4'he, 4'h9, 1'b0);
        regfile_read_instruction(7'h70, 4'hf, 4'h4, 1'b0);
    endtask

    // back-to-back pairs: control write then read, alias write beside a clashing store
    task automatic t_burst();
        logic [3:0] d;
        logic u, ok;
        core_u.burst(1'b0, 7'h21, 4'h5, 4'h0);
        core_u.answer(1'b1, d, u, ok);
        `CHK("burst answer", 1'b1, ok);
        `CHK("burst nibble", 4'h5, d);
        core_u.burst(1'b1, 7'h52, 4'h6, 4'h2);
        core_u.answer(1'b0, d, u, ok);
        `CHK("clash answer", 1'b1, ok);
        `CHK("clash nibble", 4'h6, d);
    endtask

    // mid-run reset clears controls and answers but keeps the memory
    task automatic t_reset();
        @(negedge clk_sys);
        rst_n = 1'b0;
        @(negedge clk_sys);
        `CHK("controls in reset", 256'h0, ctrl_q);
        `CHK("strobes in reset", 64'h0, ctrl_wr_stb);
        `CHK("answer in reset", 4'h0, window_out);
        rst_n = 1'b1;
        regfile_read_instruction(7'h21, 4'h0, 4'h0, 1'b0);
        regfile_read_instruction(7'h52, 4'h2, 4'h6, 1'b0);
    endtask

    initial
    begin
        #160000;
        err_count++;
        results();
    end

    initial
    begin
        repeat (10) @(negedge clk_sys);
        rst_n = 1'b1;
        `CHK("window after reset", 4'h0, window_out);
        `CHK("controls after reset", 256'h0, ctrl_q);
        t_map();
        t_flags();
        t_alias();
        t_pio();
        t_burst();
        t_reset();
        results();
    end
endmodule

`default_nettype wire
